// >>> cfd_decoder.v
// Compute field opcode decoder for the ALU, multiplier and shifter.
// Assumes the sequencer issues one compute field per cycle on CLK_SYS.
`timescale 1ns/100ps
`include "cfd_map.vh"
module cfd_decoder (
	// Clock and reset
	input wire CLK_SYS,
	input wire NRST,
	// Instruction issue
	input wire ISSUE_VALID,
	input wire [22:0] COMPUTE_FIELD,
	input wire [5:0] INSTR_TYPE,
	// Decoded controls
	output wire DEC_VALID,
	output wire [1:0] DEC_UNIT,
	output wire [3:0] DEC_CLASS,
	output wire [7:0] DEC_OPCODE,
	output wire [3:0] DEC_RN,
	output wire [3:0] DEC_RX,
	output wire [3:0] DEC_RY,
	output wire DEC_SIGN_X,
	output wire DEC_SIGN_Y,
	output wire DEC_FRAC,
	output wire DEC_ROUND,
	output wire DEC_ACC_BACK,
	output wire DEC_RES_WR,
	output wire DEC_ACC_WR,
	output wire DEC_TO_ACC,
	output wire [3:0] DEC_ACC_PART,
	output wire DEC_Y_IMM,
	output wire [7:0] DEC_IMM,
	output wire DEC_FIXED_SLICE,
	output wire DEC_FOREIGN,
	output wire DEC_UNDEF,
	// APB register port
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [7:0] PADDR,
	input wire [31:0] PWDATA,
	output wire [31:0] PRDATA,
	output wire PREADY,
	output wire PSLVERR
);
	// ================================
	// Opcode tables
	function alu_float_ok;
		input [7:0] op;
		begin
			case (op)
				`CFD_FA_ADD, `CFD_FA_SUB, `CFD_FA_ABSADD, `CFD_FA_ABSSUB,
				`CFD_FA_HALF, `CFD_FA_COMP, `CFD_FA_NEG, `CFD_FA_ABS,
				`CFD_FA_PASS, `CFD_FA_RND, `CFD_FA_SCALE: alu_float_ok = 1'b1;
				`CFD_FA_FIXBY, `CFD_FA_FIX, `CFD_FA_TRNBY, `CFD_FA_TRN,
				`CFD_FA_FLTBY, `CFD_FA_FLT: alu_float_ok = 1'b1;
				`CFD_FA_RCP, `CFD_FA_RSQ, `CFD_FA_CPSGN, `CFD_FA_MIN,
				`CFD_FA_FRAC_EXT, `CFD_FA_EXP_EXT: alu_float_ok = 1'b1;
				default: alu_float_ok = 1'b0;
			endcase
		end
	endfunction

	function [3:0] shf_class;
		input [7:0] op;
		input strm_en;
		begin
			case (op)
				`CFD_SH_EXP, `CFD_SH_EXPX, `CFD_SH_LZ, `CFD_SH_LO,
				`CFD_SH_PACK, `CFD_SH_UNPK: shf_class = `CFD_CL_SH1;
				`CFD_SH_BDEP, `CFD_SH_BEXT, `CFD_SH_BEXTNU,
				`CFD_SH_WRPW, `CFD_SH_WRPR:
					shf_class = strm_en ? `CFD_CL_STRM : `CFD_CL_NONE;
				default: shf_class = `CFD_CL_SH2;
			endcase
		end
	endfunction

	// ================================
	// Register port and control bits
	wire [1:0] ctrl;
	wire dec_en = ctrl[`CFD_CTRL_DEC_EN];
	wire strm_en = ctrl[`CFD_CTRL_STRM_EN];
	reg valid_reg;
	reg [1:0] unit_reg;
	reg [3:0] class_reg;
	reg [7:0] opcode_reg;
	reg undef_reg;
	reg foreign_reg;
	reg undef_seen_reg;
	wire [31:0] status = {16'h0, opcode_reg, class_reg, foreign_reg, undef_seen_reg, unit_reg};

	cfd_apb_regs u_regs (
		.clk(CLK_SYS),
		.nrst(NRST),
		.psel(PSEL),
		.penable(PENABLE),
		.pwrite(PWRITE),
		.paddr(PADDR),
		.pwdata(PWDATA),
		.prdata(PRDATA),
		.pready(PREADY),
		.pslverr(PSLVERR),
		.status_in(status),
		.undef_pulse(undef_reg),
		.ctrl_out(ctrl)
	);

	// ================================
	// Field extraction
	wire [7:0] opc = COMPUTE_FIELD[`CFD_OPC_HI:`CFD_OPC_LO];
	wire [5:0] imm_opc = COMPUTE_FIELD[`CFD_IMM_OPC_HI:`CFD_IMM_OPC_LO];
	wire [1:0] unit_sel = COMPUTE_FIELD[`CFD_UNIT_HI:`CFD_UNIT_LO];
	wire [1:0] dst = opc[2:1];

	// ================================
	// Next values of the decoded controls
	reg valid_next;
	reg [1:0] unit_next;
	reg [3:0] class_next;
	reg [7:0] opcode_next;
	reg [3:0] rn_next;
	reg [3:0] rx_next;
	reg [3:0] ry_next;
	reg sx_next;
	reg sy_next;
	reg frac_next;
	reg round_next;
	reg back_next;
	reg res_wr_next;
	reg acc_wr_next;
	reg to_acc_next;
	reg [3:0] part_next;
	reg y_imm_next;
	reg [7:0] imm_next;
	reg slice_next;
	reg foreign_next;
	reg undef_next;

	// Main decode
	always @* begin
		valid_next = 1'b0;
		unit_next = unit_sel;
		class_next = `CFD_CL_NONE;
		opcode_next = opc;
		rn_next = COMPUTE_FIELD[11:8];
		rx_next = COMPUTE_FIELD[7:4];
		ry_next = COMPUTE_FIELD[3:0];
		sx_next = 1'b0;
		sy_next = 1'b0;
		frac_next = 1'b0;
		round_next = 1'b0;
		back_next = 1'b0;
		res_wr_next = 1'b0;
		acc_wr_next = 1'b0;
		to_acc_next = 1'b0;
		part_next = 4'h0;
		y_imm_next = 1'b0;
		imm_next = 8'h0;
		slice_next = 1'b0;
		foreign_next = 1'b0;
		if (ISSUE_VALID & dec_en) begin
			valid_next = 1'b1;
			if (INSTR_TYPE == `CFD_TYPE_SHIFT_IMM) begin
				// Immediate shift: y comes from the instruction
				unit_next = `CFD_UNIT_SHF;
				opcode_next = {imm_opc, 2'b00};
				class_next = shf_class({imm_opc, 2'b00}, strm_en);
				imm_next = COMPUTE_FIELD[15:8];
				rn_next = COMPUTE_FIELD[7:4];
				rx_next = COMPUTE_FIELD[3:0];
				ry_next = 4'h0;
				y_imm_next = 1'b1;
				slice_next = 1'b1;
				res_wr_next = 1'b1;
			end else if (COMPUTE_FIELD[22:17] == `CFD_MRX_TAG) begin
				// Accumulator slice transfer
				unit_next = `CFD_UNIT_MUL;
				class_next = `CFD_CL_XFER;
				opcode_next = 8'h0;
				to_acc_next = COMPUTE_FIELD[16];
				part_next = COMPUTE_FIELD[15:12];
				rn_next = COMPUTE_FIELD[11:8];
				back_next = COMPUTE_FIELD[14];
				if ((COMPUTE_FIELD[15] == 1'b0) & (COMPUTE_FIELD[13:12] != 2'h3)) begin
					res_wr_next = ~COMPUTE_FIELD[16];
					acc_wr_next = COMPUTE_FIELD[16];
				end else begin
					class_next = `CFD_CL_NONE;
				end
			end else if (COMPUTE_FIELD[`CFD_MULTI_BIT]) begin
				// Multifunction forms are decoded elsewhere
				foreign_next = 1'b1;
			end else begin
				slice_next = (unit_sel == `CFD_UNIT_SHF);
				case (unit_sel)
					`CFD_UNIT_ALU: begin
						if (!opc[7]) begin
							foreign_next = 1'b1;
						end else if (alu_float_ok(opc)) begin
							class_next = `CFD_CL_ALUF;
							res_wr_next = (opc != `CFD_FA_COMP);
						end
					end
					`CFD_UNIT_MUL: begin
						if (opc == `CFD_MU_FMUL) begin
							class_next = `CFD_CL_FMUL;
							res_wr_next = 1'b1;
						end else if (opc[7:6] != 2'h0) begin
							// Product, accumulate or subtract
							sy_next = opc[5];
							sx_next = opc[4];
							frac_next = opc[3];
							round_next = opc[0] & ~dst[1];
							back_next = dst[0];
							case (opc[7:6])
								`CFD_MG_PROD: class_next = `CFD_CL_PROD;
								`CFD_MG_ADD: class_next = `CFD_CL_MADD;
								`CFD_MG_SUB: class_next = `CFD_CL_MSUB;
								default: class_next = `CFD_CL_NONE;
							endcase
							if ((opc[7:6] == `CFD_MG_PROD) & (dst == 2'h1)) begin
								class_next = `CFD_CL_NONE;
							end else begin
								res_wr_next = ~dst[1];
								acc_wr_next = dst[1];
							end
						end else if (opc[7:4] == `CFD_MG_SAT) begin
							// Saturation takes integer forms only
							sx_next = opc[0];
							sy_next = opc[0];
							back_next = dst[0];
							if (!opc[3]) begin
								class_next = `CFD_CL_SAT;
								res_wr_next = ~dst[1];
								acc_wr_next = dst[1];
							end
						end else if (opc[7:4] == `CFD_MG_RND) begin
							if (opc[3]) begin
								class_next = `CFD_CL_RND;
								sx_next = opc[0];
								sy_next = opc[0];
								frac_next = 1'b1;
								back_next = dst[0];
								res_wr_next = ~dst[1];
								acc_wr_next = dst[1];
							end else if ((opc == `CFD_MU_CLRF) | (opc == `CFD_MU_CLRB)) begin
								class_next = `CFD_CL_CLR;
								back_next = opc[1];
								acc_wr_next = 1'b1;
							end
						end
					end
					`CFD_UNIT_SHF: begin
						class_next = shf_class(opc, strm_en);
						res_wr_next = (class_next != `CFD_CL_NONE);
						y_imm_next = 1'b0;
					end
					default: class_next = `CFD_CL_NONE;
				endcase
			end
		end
		undef_next = valid_next & ~foreign_next & (class_next == `CFD_CL_NONE);
		if (undef_next) begin
			// Undefined opcode writes nothing
			res_wr_next = 1'b0;
			acc_wr_next = 1'b0;
		end
	end

	// ================================
	// Output registers
	reg [3:0] rn_reg;
	reg [3:0] rx_reg;
	reg [3:0] ry_reg;
	reg sx_reg;
	reg sy_reg;
	reg frac_reg;
	reg round_reg;
	reg back_reg;
	reg res_wr_reg;
	reg acc_wr_reg;
	reg to_acc_reg;
	reg [3:0] part_reg;
	reg y_imm_reg;
	reg [7:0] imm_reg;
	reg slice_reg;

	// Decoded controls leave one edge after issue
	always @(posedge CLK_SYS) begin
		if (!NRST) begin
			valid_reg <= 1'b0;
			unit_reg <= 2'h0;
			class_reg <= `CFD_CL_NONE;
			opcode_reg <= 8'h0;
			rn_reg <= 4'h0;
			rx_reg <= 4'h0;
			ry_reg <= 4'h0;
			sx_reg <= 1'b0;
			sy_reg <= 1'b0;
			frac_reg <= 1'b0;
			round_reg <= 1'b0;
			back_reg <= 1'b0;
			res_wr_reg <= 1'b0;
			acc_wr_reg <= 1'b0;
			to_acc_reg <= 1'b0;
			part_reg <= 4'h0;
			y_imm_reg <= 1'b0;
			imm_reg <= 8'h0;
			slice_reg <= 1'b0;
			foreign_reg <= 1'b0;
			undef_reg <= 1'b0;
		end else begin
			valid_reg <= valid_next;
			unit_reg <= unit_next;
			class_reg <= class_next;
			opcode_reg <= opcode_next;
			rn_reg <= rn_next;
			rx_reg <= rx_next;
			ry_reg <= ry_next;
			sx_reg <= sx_next;
			sy_reg <= sy_next;
			frac_reg <= frac_next;
			round_reg <= round_next;
			back_reg <= back_next;
			res_wr_reg <= res_wr_next;
			acc_wr_reg <= acc_wr_next;
			to_acc_reg <= to_acc_next;
			part_reg <= part_next;
			y_imm_reg <= y_imm_next;
			imm_reg <= imm_next;
			slice_reg <= slice_next;
			foreign_reg <= foreign_next;
			undef_reg <= undef_next;
		end
	end

	// Undefined flag of the last valid issue, for the status register
	always @(posedge CLK_SYS) begin
		if (!NRST)
			undef_seen_reg <= 1'b0;
		else if (valid_next)
			undef_seen_reg <= undef_next;
	end

	// ================================
	// Port drive
	assign DEC_VALID = valid_reg;
	assign DEC_UNIT = unit_reg;
	assign DEC_CLASS = class_reg;
	assign DEC_OPCODE = opcode_reg;
	assign DEC_RN = rn_reg;
	assign DEC_RX = rx_reg;
	assign DEC_RY = ry_reg;
	assign DEC_SIGN_X = sx_reg;
	assign DEC_SIGN_Y = sy_reg;
	assign DEC_FRAC = frac_reg;
	assign DEC_ROUND = round_reg;
	assign DEC_ACC_BACK = back_reg;
	assign DEC_RES_WR = res_wr_reg;
	assign DEC_ACC_WR = acc_wr_reg;
	assign DEC_TO_ACC = to_acc_reg;
	assign DEC_ACC_PART = part_reg;
	assign DEC_Y_IMM = y_imm_reg;
	assign DEC_IMM = imm_reg;
	assign DEC_FIXED_SLICE = slice_reg;
	assign DEC_FOREIGN = foreign_reg;
	assign DEC_UNDEF = undef_reg;
endmodule

// >>> cfd_map.vh
// Constants of the compute field opcode decoder: fields, opcodes, classes, registers.
// Assumes inclusion by bare name from the decoder design files.
`ifndef CFD_MAP_VH
`define CFD_MAP_VH
// ================================
// Compute field layout
`define CFD_MULTI_BIT 22
`define CFD_UNIT_HI 21
`define CFD_UNIT_LO 20
`define CFD_OPC_HI 19
`define CFD_OPC_LO 12
`define CFD_IMM_OPC_HI 21
`define CFD_IMM_OPC_LO 16
`define CFD_TYPE_SHIFT_IMM 6'h06
`define CFD_MRX_TAG 6'h20
// ================================
// Unit select codes
`define CFD_UNIT_ALU 2'h0
`define CFD_UNIT_MUL 2'h1
`define CFD_UNIT_SHF 2'h2
// ================================
// Float ALU opcodes
`define CFD_FA_ADD 8'h81
`define CFD_FA_SUB 8'h82
`define CFD_FA_ABSADD 8'h91
`define CFD_FA_ABSSUB 8'h92
`define CFD_FA_HALF 8'h89
`define CFD_FA_COMP 8'h8a
`define CFD_FA_NEG 8'ha2
`define CFD_FA_ABS 8'hb0
`define CFD_FA_PASS 8'ha1
`define CFD_FA_RND 8'ha5
`define CFD_FA_SCALE 8'hbd
`define CFD_FA_FRAC_EXT 8'had
`define CFD_FA_EXP_EXT 8'hc1
`define CFD_FA_FIXBY 8'hd9
`define CFD_FA_FIX 8'hc9
`define CFD_FA_TRNBY 8'hdd
`define CFD_FA_TRN 8'hcd
`define CFD_FA_FLTBY 8'hda
`define CFD_FA_FLT 8'hca
`define CFD_FA_RCP 8'hc4
`define CFD_FA_RSQ 8'hc5
`define CFD_FA_CPSGN 8'he0
`define CFD_FA_MIN 8'he1
// ================================
// Multiplier opcodes and groups
`define CFD_MU_FMUL 8'h30
`define CFD_MU_CLRF 8'h14
`define CFD_MU_CLRB 8'h16
`define CFD_MG_PROD 2'h1
`define CFD_MG_ADD 2'h2
`define CFD_MG_SUB 2'h3
`define CFD_MG_SAT 4'h0
`define CFD_MG_RND 4'h1
// ================================
// Shifter opcodes
`define CFD_SH_EXP 8'h80
`define CFD_SH_EXPX 8'h84
`define CFD_SH_LZ 8'h88
`define CFD_SH_LO 8'h8c
`define CFD_SH_PACK 8'h90
`define CFD_SH_UNPK 8'h94
`define CFD_SH_BDEP 8'h74
`define CFD_SH_BEXT 8'h50
`define CFD_SH_BEXTNU 8'h58
`define CFD_SH_WRPW 8'h7c
`define CFD_SH_WRPR 8'h70
`define CFD_SHF_SLICE_HI 38
`define CFD_SHF_SLICE_LO 9
// ================================
// Decoded operation classes
`define CFD_CL_NONE 4'h0
`define CFD_CL_ALUF 4'h1
`define CFD_CL_PROD 4'h2
`define CFD_CL_MADD 4'h3
`define CFD_CL_MSUB 4'h4
`define CFD_CL_SAT 4'h5
`define CFD_CL_RND 4'h6
`define CFD_CL_CLR 4'h7
`define CFD_CL_FMUL 4'h8
`define CFD_CL_XFER 4'h9
`define CFD_CL_SH1 4'ha
`define CFD_CL_SH2 4'hb
`define CFD_CL_STRM 4'hc
// ================================
// Register offsets and reset values
`define CFD_REG_CTRL 8'h00
`define CFD_REG_STATUS 8'h04
`define CFD_REG_UNDEF 8'h08
`define CFD_CTRL_RST 2'h3
`define CFD_CTRL_DEC_EN 0
`define CFD_CTRL_STRM_EN 1
`endif

// >>> cfd_apb_regs.v
// APB register slave of the compute field decoder.
// Assumes a single clock with the decoder and a well-behaved APB master.
`timescale 1ns/100ps
`include "cfd_map.vh"
module cfd_apb_regs (
	// Clock and reset
	input wire clk,
	input wire nrst,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Decoder side
	input wire [31:0] status_in,
	input wire undef_pulse,
	output wire [1:0] ctrl_out
);
	reg [1:0] ctrl_reg;
	reg [15:0] undef_cnt_reg;
	reg [31:0] prdata_reg;
	reg pready_reg;
	reg pslverr_reg;
	wire setup_ph = psel & ~penable;
	wire wr_done = psel & penable & pready_reg & pwrite;
	wire hit = (paddr == `CFD_REG_CTRL) | (paddr == `CFD_REG_STATUS) | (paddr == `CFD_REG_UNDEF);
	// ================================
	// Answer prepared in setup, ready in access phase
	always @(posedge clk) begin
		if (!nrst) begin
			prdata_reg <= 32'h0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= setup_ph;
			pslverr_reg <= setup_ph & ~hit;
			if (setup_ph & ~pwrite) begin
				case (paddr)
					`CFD_REG_CTRL: prdata_reg <= {30'h0, ctrl_reg};
					`CFD_REG_STATUS: prdata_reg <= status_in;
					`CFD_REG_UNDEF: prdata_reg <= {16'h0, undef_cnt_reg};
					default: prdata_reg <= 32'h0;
				endcase
			end else begin
				prdata_reg <= 32'h0;
			end
		end
	end
	// Control write and undefined counter; a count wins over a clear
	always @(posedge clk) begin
		if (!nrst) begin
			ctrl_reg <= `CFD_CTRL_RST;
			undef_cnt_reg <= 16'h0;
		end else begin
			if (wr_done & (paddr == `CFD_REG_CTRL))
				ctrl_reg <= pwdata[1:0];
			if (undef_pulse & (undef_cnt_reg != 16'hffff))
				undef_cnt_reg <= undef_cnt_reg + 16'h1;
			else if (wr_done & (paddr == `CFD_REG_UNDEF))
				undef_cnt_reg <= 16'h0;
		end
	end
	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign ctrl_out = ctrl_reg;
endmodule

// >>> cfd_assertions.sv
// Port checker of the compute field opcode decoder.
// Assumes binding to cfd_decoder; decode enables are shadowed from APB writes.
`timescale 1ns/100ps
module cfd_assertions (
	// Clock, reset and issue
	input logic CLK_SYS,
	input logic NRST,
	input logic ISSUE_VALID,
	input logic [22:0] COMPUTE_FIELD,
	input logic [5:0] INSTR_TYPE,
	// Decoded controls
	input logic DEC_VALID,
	input logic [1:0] DEC_UNIT,
	input logic [3:0] DEC_CLASS,
	input logic [7:0] DEC_OPCODE,
	input logic DEC_SIGN_X,
	input logic DEC_SIGN_Y,
	input logic DEC_FRAC,
	input logic DEC_ROUND,
	input logic DEC_ACC_BACK,
	input logic DEC_RES_WR,
	input logic DEC_ACC_WR,
	input logic DEC_TO_ACC,
	input logic [3:0] DEC_ACC_PART,
	input logic DEC_Y_IMM,
	input logic DEC_FIXED_SLICE,
	input logic DEC_UNDEF,
	// APB
	input logic PSEL,
	input logic PENABLE,
	input logic PWRITE,
	input logic [7:0] PADDR,
	input logic [31:0] PWDATA,
	input logic PREADY
);
	// ================================
	// Helpers
	logic [1:0] en_reg;
	wire [7:0] op = COMPUTE_FIELD[19:12];
	wire go = ISSUE_VALID && en_reg[0] && INSTR_TYPE != 6'h06;
	wire alu = go && COMPUTE_FIELD[22:20] == 3'b000;
	wire mul = go && COMPUTE_FIELD[22:20] == 3'b001;
	wire shf = go && COMPUTE_FIELD[22:20] == 3'b010;
	wire mac = mul && op[7:6] != 2'h0;
	wire xf = go && COMPUTE_FIELD[22:17] == 6'h20 && !COMPUTE_FIELD[15] && COMPUTE_FIELD[13:12] != 2'h3;
	// Shadow of the control register, written at the APB access edge
	always @(posedge CLK_SYS) begin
		if (!NRST)
			en_reg <= 2'h3;
		else if (PSEL && PENABLE && PWRITE && PREADY && PADDR == 8'h00)
			en_reg <= PWDATA[1:0];
	end
	// ================================
	// Properties
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!NRST);
	property p_valid; ISSUE_VALID && en_reg[0] |=> DEC_VALID; endproperty
	a_valid: assert property (p_valid) else $error("decode missing");
	property p_idle; !(ISSUE_VALID && en_reg[0]) |=> !DEC_VALID; endproperty
	a_idle: assert property (p_idle) else $error("decode without issue");
	property p_falu; alu && op == 8'h81 |=> DEC_CLASS == 4'h1 && DEC_UNIT == 2'h0 && DEC_RES_WR; endproperty
	a_falu: assert property (p_falu) else $error("float add wrong");
	property p_sign; mac |=> DEC_UNDEF || {DEC_SIGN_Y, DEC_SIGN_X, DEC_FRAC} == $past(op[5:3]); endproperty
	a_sign: assert property (p_sign) else $error("multiply modifiers wrong");
	property p_group; mac |=> DEC_UNDEF || DEC_CLASS == 4'h1 + $past(op[7:6]) && DEC_ACC_WR == $past(op[2]); endproperty
	a_group: assert property (p_group) else $error("multiply group wrong");
	property p_round; mac && !op[2] |=> DEC_UNDEF || DEC_ROUND == $past(op[0]); endproperty
	a_round: assert property (p_round) else $error("rounding wrong");
	property p_clear; mul && (op == 8'h14 || op == 8'h16) |=> DEC_CLASS == 4'h7 && DEC_ACC_BACK == $past(op[1]); endproperty
	a_clear: assert property (p_clear) else $error("clear wrong");
	property p_fmul; mul && op == 8'h30 |=> DEC_CLASS == 4'h8 && DEC_RES_WR; endproperty
	a_fmul: assert property (p_fmul) else $error("float multiply wrong");
	property p_undef; DEC_UNDEF |-> DEC_CLASS == 4'h0 && !DEC_RES_WR && !DEC_ACC_WR; endproperty
	a_undef: assert property (p_undef) else $error("undefined op writes");
	property p_xfer; xf |=> DEC_CLASS == 4'h9 && {DEC_TO_ACC, DEC_ACC_PART} == $past(COMPUTE_FIELD[16:12]); endproperty
	a_xfer: assert property (p_xfer) else $error("transfer wrong");
	property p_imm;
		ISSUE_VALID && en_reg[0] && INSTR_TYPE == 6'h06 |=>
			DEC_UNDEF || DEC_Y_IMM && DEC_UNIT == 2'h2 && DEC_OPCODE == {$past(COMPUTE_FIELD[21:16]), 2'b00};
	endproperty
	a_imm: assert property (p_imm) else $error("immediate shift wrong");
	property p_noimm; go |=> !DEC_Y_IMM; endproperty
	a_noimm: assert property (p_noimm) else $error("immediate outside type six");
	property p_strm; shf && !en_reg[1] && (op == 8'h74 || op == 8'h7c) |=> DEC_UNDEF; endproperty
	a_strm: assert property (p_strm) else $error("bitstream op not refused");
	property p_slice; DEC_VALID && DEC_UNIT == 2'h2 && !DEC_UNDEF |-> DEC_FIXED_SLICE; endproperty
	a_slice: assert property (p_slice) else $error("shifter slice wrong");
endmodule
bind cfd_decoder cfd_assertions i_chk (.CLK_SYS, .NRST, .ISSUE_VALID, .COMPUTE_FIELD, .INSTR_TYPE, .DEC_VALID,
	.DEC_UNIT, .DEC_CLASS, .DEC_OPCODE, .DEC_SIGN_X, .DEC_SIGN_Y, .DEC_FRAC, .DEC_ROUND, .DEC_ACC_BACK, .DEC_RES_WR,
	.DEC_ACC_WR, .DEC_TO_ACC, .DEC_ACC_PART, .DEC_Y_IMM, .DEC_FIXED_SLICE, .DEC_UNDEF, .PSEL, .PENABLE, .PWRITE,
	.PADDR, .PWDATA, .PREADY);

// >>> cfd_seq_model.sv
// Sequencer model that issues compute fields to the decoder.
// Assumes the decoder samples the issue lines at the rising clock edge.
`timescale 1ns/100ps
module cfd_seq_model (
	// Clock
	input logic clk,
	// Issue lines
	output logic issue_valid,
	output logic [22:0] field,
	output logic [5:0] itype
);
	// ================================
	// Idle lines at start
	initial begin
		issue_valid = 1'b0;
		field = 23'h0;
		itype = 6'h0;
	end
	// One field after an optional stall, then scrambled lines
	task automatic issue(input logic [22:0] f, input logic [5:0] t, input int gap);
		repeat (gap) @(posedge clk);
		@(posedge clk);
		issue_valid <= 1'b1;
		field <= f;
		itype <= t;
		@(posedge clk);
		issue_valid <= 1'b0;
		field <= ~f;
		itype <= ~t;
	endtask
endmodule

// >>> cfd_decoder_tb.sv
// Self-checking testbench of the compute field opcode decoder.
// Assumes the decoder, the sequencer model and the checker are compiled first.
`timescale 1ns/100ps
module cfd_decoder_tb;
	// ================================
	// Signals
	logic CLK_SYS, NRST, PSEL, PENABLE, PWRITE;
	logic [7:0] PADDR;
	logic [31:0] PWDATA, rd;
	logic er;
	wire ISSUE_VALID, PREADY, PSLVERR, DEC_VALID, DEC_SIGN_X, DEC_SIGN_Y, DEC_FRAC, DEC_ROUND, DEC_ACC_BACK;
	wire DEC_RES_WR, DEC_ACC_WR, DEC_TO_ACC, DEC_Y_IMM, DEC_FIXED_SLICE, DEC_FOREIGN, DEC_UNDEF;
	wire [22:0] COMPUTE_FIELD;
	wire [5:0] INSTR_TYPE;
	wire [1:0] DEC_UNIT;
	wire [3:0] DEC_CLASS, DEC_RN, DEC_RX, DEC_RY, DEC_ACC_PART;
	wire [7:0] DEC_OPCODE, DEC_IMM;
	wire [31:0] PRDATA;
	int n_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	localparam logic [7:0] FA [23] = '{8'h81, 8'h82, 8'h89, 8'h8a, 8'ha2, 8'hb0, 8'ha1, 8'hc9, 8'hd9, 8'hcd,
		8'hdd, 8'hca, 8'hda, 8'hc4, 8'hc5, 8'he0, 8'he1, 8'had, 8'hc1, 8'h91, 8'h92, 8'ha5, 8'hbd};
	localparam logic [7:0] SH [13] = '{8'h80, 8'h84, 8'h88, 8'h8c, 8'h90, 8'h94, 8'h74, 8'h50, 8'h58, 8'h7c,
		8'h70, 8'h00, 8'h44};
	// ================================
	// Instances
	cfd_seq_model i_seq (.clk(CLK_SYS), .issue_valid(ISSUE_VALID), .field(COMPUTE_FIELD), .itype(INSTR_TYPE));
	cfd_decoder i_dut (.CLK_SYS, .NRST, .ISSUE_VALID, .COMPUTE_FIELD, .INSTR_TYPE, .DEC_VALID, .DEC_UNIT,
		.DEC_CLASS, .DEC_OPCODE, .DEC_RN, .DEC_RX, .DEC_RY, .DEC_SIGN_X, .DEC_SIGN_Y, .DEC_FRAC, .DEC_ROUND,
		.DEC_ACC_BACK, .DEC_RES_WR, .DEC_ACC_WR, .DEC_TO_ACC, .DEC_ACC_PART, .DEC_Y_IMM, .DEC_IMM,
		.DEC_FIXED_SLICE, .DEC_FOREIGN, .DEC_UNDEF, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
		.PSLVERR);
	// Clock of 50 ns
	initial begin
		CLK_SYS = 1'b0;
		forever #25 CLK_SYS = ~CLK_SYS;
	end
	// Hang guard
	always @(posedge CLK_SYS) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_errors++;
			report_and_stop;
		end
	end
	// ================================
	// Shared tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_SYS);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLK_SYS);
		PENABLE <= 1'b1;
		do @(posedge CLK_SYS); while (PREADY !== 1'b1);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	// Issue one field and judge the common controls
	task automatic dec(input logic [22:0] f, input logic [5:0] t, input logic [3:0] c, input logic [1:0] u);
		i_seq.issue(f, t, 0);
		#1;
		chk("valid", 1'b1, DEC_VALID);
		chk("class", c, DEC_CLASS);
		chk("unit", u, DEC_UNIT);
		chk("undef", c == 4'h0, DEC_UNDEF);
	endtask
	task automatic report_and_stop;
		if (n_errors == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ================================
	// Scenarios
	task automatic t_regs;
		apb(1'b0, 8'h00, 32'h0);
		chk("ctrl", 32'h3, rd);
		apb(1'b1, 8'h00, 32'h0);
		i_seq.issue({3'b001, 8'h30, 12'h0}, 6'h1, 0);
		#1;
		chk("off", 1'b0, DEC_VALID);
		apb(1'b1, 8'h00, 32'h3);
		apb(1'b1, 8'h08, 32'h0);
		dec({3'b000, 8'hff, 12'h0}, 6'h1, 4'h0, 2'h0);
		chk("wr", 2'b00, {DEC_RES_WR, DEC_ACC_WR});
		apb(1'b0, 8'h08, 32'h0);
		chk("count", 32'h1, rd);
		apb(1'b0, 8'h04, 32'h0);
		chk("status", 32'h7, rd);
		apb(1'b0, 8'h0c, 32'h0);
		chk("slverr", 1'b1, er);
		chk("rdata", 32'h0, rd);
	endtask
	task automatic t_alu;
		for (int i = 0; i < 23; i++) begin
			dec({3'b000, FA[i], 12'h359}, 6'h1, 4'h1, 2'h0);
			chk("op", {FA[i], 12'h359}, {DEC_OPCODE, DEC_RN, DEC_RX, DEC_RY});
			chk("reswr", FA[i] != 8'h8a, DEC_RES_WR);
		end
		// Fixed-point ALU and multifunction forms are passed on, not undefined
		i_seq.issue({3'b000, 8'h01, 12'h0}, 6'h1, 0);
		#1;
		chk("foreign", 3'b110, {DEC_VALID, DEC_FOREIGN, DEC_UNDEF});
		i_seq.issue({3'b101, 8'h81, 12'h0}, 6'h1, 0);
		#1;
		chk("multi", 3'b110, {DEC_VALID, DEC_FOREIGN, DEC_UNDEF});
		dec({3'b011, 8'h81, 12'h0}, 6'h1, 4'h0, 2'h3);
		chk("unit3", 1'b0, DEC_FOREIGN);
	endtask
	task automatic t_mul;
		logic [7:0] op;
		logic bad;
		for (int o = 64; o < 256; o++) begin
			op = o[7:0];
			bad = op[7:6] == 2'h1 && op[2:1] == 2'h1;
			i_seq.issue({3'b001, op, 12'h123}, 6'h1, o % 2);
			#1;
			chk("mclass", bad ? 4'h0 : 4'h1 + op[7:6], DEC_CLASS);
			if (!bad) begin
				chk("mods", {op[5:3], op[0] & !op[2]}, {DEC_SIGN_Y, DEC_SIGN_X, DEC_FRAC, DEC_ROUND});
				chk("mwr", {op[2], !op[2]}, {DEC_ACC_WR, DEC_RES_WR});
			end
		end
	endtask
	task automatic t_acc;
		logic [7:0] op;
		logic [3:0] c;
		for (int o = 0; o < 32; o++) begin
			op = o[7:0];
			c = op[3] ? (op[4] ? 4'h6 : 4'h0) : (!op[4] ? 4'h5 : (op == 8'h14 || op == 8'h16) ? 4'h7 : 4'h0);
			dec({3'b001, op, 12'h0}, 6'h1, c, 2'h1);
			if (c != 4'h0)
				chk("acc", {op[1], op[2], !op[2]}, {DEC_ACC_BACK, DEC_ACC_WR, DEC_RES_WR});
			if (c == 4'h5 || c == 4'h6)
				chk("mod", {op[0], op[0], c == 4'h6}, {DEC_SIGN_X, DEC_SIGN_Y, DEC_FRAC});
		end
		dec({3'b001, 8'h30, 12'h0}, 6'h1, 4'h8, 2'h1);
		chk("fmul", 1'b1, DEC_RES_WR);
	endtask
	task automatic t_xfer;
		logic ok;
		for (int i = 0; i < 32; i++) begin
			ok = !i[3] && i[1:0] != 2'h3;
			dec({6'h20, i[4], i[3:0], 4'ha, 8'h00}, 6'h1, ok ? 4'h9 : 4'h0, 2'h1);
			if (ok)
				chk("xfer", {i[4], i[3:0], 4'ha}, {DEC_TO_ACC, DEC_ACC_PART, DEC_RN});
		end
	endtask
	task automatic t_shf;
		for (int i = 0; i < 13; i++) begin
			dec({3'b010, SH[i], 12'h0}, 6'h1, i < 6 ? 4'ha : i < 11 ? 4'hc : 4'hb, 2'h2);
			chk("slice", 2'b10, {DEC_FIXED_SLICE, DEC_Y_IMM});
		end
		apb(1'b1, 8'h00, 32'h1);
		for (int i = 6; i < 11; i++)
			dec({3'b010, SH[i], 12'h0}, 6'h1, 4'h0, 2'h2);
		apb(1'b1, 8'h00, 32'h3);
		dec({1'b0, 6'h11, 8'h5a, 8'h37}, 6'h06, 4'hb, 2'h2);
		chk("imm", {1'b1, 8'h44, 8'h5a, 8'h37}, {DEC_Y_IMM, DEC_OPCODE, DEC_IMM, DEC_RN, DEC_RX});
	endtask
	// ================================
	// Main sequence
	initial begin
		NRST = 1'b0;
		PSEL = 1'b0;
		PENABLE = 1'b0;
		PWRITE = 1'b0;
		PADDR = 8'h00;
		PWDATA = 32'h0;
		repeat (6) @(posedge CLK_SYS);
		NRST <= 1'b1;
		chk("reset", 1'b0, DEC_VALID);
		t_regs;
		t_alu;
		t_mul;
		t_acc;
		t_xfer;
		t_shf;
		report_and_stop;
	end
endmodule
